// ### common/pfcg_defs.svh
// Behaviour
// (RULE1) Writing the unlock key to lock_key unlocks the port.
// (RULE2) Any other lock_key value, or any commit_mask write, relocks the port.
// (RULE3) Reading lock_key returns one when locked, zero when unlocked.
// (RULE4) Zero commit bit discards the write to that alt_function_select bit.
// (RULE5) One commit bit lets the written alt_function_select bit through.
// (RULE6) Writes to commit_mask are ignored while locked.
// (RULE7) Commit bits sit in bits 7:0, one per pin.
// (RULE8) Commit bits of ordinary pins are hardwired to one.
// (RULE9) Only port_b_pin7 and port_c_low_pins commit bits are writable.
// (RULE10) Commit mask resets to 0x7F on port B and 0xF0 on port C.
// (RULE11) Bits 31:8 of commit_mask and identification registers read zero.
// (RULE12) Identification registers each supply one byte of a 32-bit identifier.
// (RULE13) Identification registers sit at 0xFD0 to 0xFE4 and ignore writes.
// (RULE14) A newly written commit mask governs the very next select write.
`ifndef PFCG_DEFS_SVH
`define PFCG_DEFS_SVH
`define PFCG_OFS_AFSEL 12'h420
`define PFCG_OFS_LOCK 12'h520
`define PFCG_OFS_COMMIT 12'h524
`define PFCG_OFS_ID4 12'hFD0
`define PFCG_OFS_ID5 12'hFD4
`define PFCG_OFS_ID6 12'hFD8
`define PFCG_OFS_ID7 12'hFDC
`define PFCG_OFS_ID0 12'hFE0
`define PFCG_OFS_ID1 12'hFE4
`define PFCG_UNLOCK_KEY 32'h1ACC_E551
`define PFCG_LOCKED_WORD 32'h0000_0001
`define PFCG_UNLOCKED_WORD 32'h0000_0000
`define PFCG_ALL_ONES 8'hFF
`define PFCG_PORT_B_WRITABLE 8'h80
`define PFCG_PORT_C_WRITABLE 8'h0F
`define PFCG_PORT_B_AFSEL_RST 8'h80
`define PFCG_PORT_C_AFSEL_RST 8'h0F
`define PFCG_PORT_A 3'h0
`define PFCG_PORT_B 3'h1
`define PFCG_PORT_C 3'h2
`define PFCG_NO_DEBUG_PINS 8'h00
`define PFCG_IDLE_WORD 32'h0000_0000
`endif

// ### common/pfcg_pkg.sv
package pfcg_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } pfcg_bus_type;
    typedef enum logic {PFCG_LOCKED, PFCG_UNLOCKED} pfcg_lock_type;
endpackage : pfcg_pkg

// ### src/pfcg_mask_bit.sv
`timescale 1ns/100ps
`default_nettype none
module pfcg_mask_bit #(
    parameter bit WRITABLE = 1'b0,
    parameter bit RST = 1'b1,
    parameter bit SEL_RST = 1'b0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic mask_we,
    input wire logic mask_wbit,
    input wire logic sel_we,
    input wire logic sel_wbit,
    output logic mask_bit,
    output logic sel_bit
);
    logic mask_r;
    logic mask_nxt;
    logic sel_r;
    logic sel_nxt;
    always_comb begin
        mask_nxt = mask_r;
        sel_nxt = sel_r;
        if (WRITABLE && mask_we) begin
            mask_nxt = mask_wbit; // RULE9
        end
        if (sel_we && mask_r) begin
            sel_nxt = sel_wbit; // RULE5
        end
        // Otherwise the select bit holds its value. RULE4
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mask_r <= RST; // RULE10
            sel_r <= SEL_RST;
        end else begin
            mask_r <= mask_nxt;
            sel_r <= sel_nxt;
        end
    end
    // Ordinary pins have no commit-bit storage left after synthesis. RULE8
    assign mask_bit = WRITABLE ? mask_r : 1'b1;
    assign sel_bit = sel_r;
endmodule : pfcg_mask_bit
`default_nettype wire

// ### src/pfcg_commit_guard.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfcg_defs.svh"
module pfcg_commit_guard #(
    parameter logic [2:0] PORT_ID = `PFCG_PORT_B,
    // Identifier value is arbitrary.
    parameter logic [31:0] IDENT_LO = 32'h0000_0000,
    // Identifier value is arbitrary.
    parameter logic [31:0] IDENT_HI = 32'h0000_0000
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic write,
    input wire logic read,
    output logic [31:0] rdata,
    output logic [7:0] alt_function_select,
    output logic [7:0] commit_bits,
    output logic locked
);
    pfcg_pkg::pfcg_bus_type bus;
    pfcg_pkg::pfcg_lock_type lock_r;
    pfcg_pkg::pfcg_lock_type lock_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    // Parameter overrides need constants, so both masks are elaborated from PORT_ID.
    localparam logic [7:0] WRITABLE_MASK = (PORT_ID == `PFCG_PORT_B) ? `PFCG_PORT_B_WRITABLE :
        (PORT_ID == `PFCG_PORT_C) ? `PFCG_PORT_C_WRITABLE : `PFCG_NO_DEBUG_PINS;
    localparam logic [7:0] SEL_RST_MASK = (PORT_ID == `PFCG_PORT_B) ? `PFCG_PORT_B_AFSEL_RST :
        (PORT_ID == `PFCG_PORT_C) ? `PFCG_PORT_C_AFSEL_RST : `PFCG_NO_DEBUG_PINS;
    logic mask_we;
    logic sel_we;
    assign bus = '{addr: addr, wdata: wdata, write: write, read: read};
    assign mask_we = bus.write && bus.addr == `PFCG_OFS_COMMIT && lock_r == pfcg_pkg::PFCG_UNLOCKED; // RULE6
    assign sel_we = bus.write && bus.addr == `PFCG_OFS_AFSEL;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            pfcg_mask_bit #(
                .WRITABLE(WRITABLE_MASK[g]),
                .RST(~WRITABLE_MASK[g]),
                .SEL_RST(SEL_RST_MASK[g])
            ) u_bit (
                .clock(clock),
                .reset(reset),
                .mask_we(mask_we),
                .mask_wbit(bus.wdata[g]), // RULE7
                .sel_we(sel_we),
                .sel_wbit(bus.wdata[g]),
                .mask_bit(commit_bits[g]), // RULE14
                .sel_bit(alt_function_select[g])
            );
        end
    endgenerate
    always_comb begin
        lock_nxt = lock_r;
        if (bus.write && bus.addr == `PFCG_OFS_LOCK) begin
            if (bus.wdata == `PFCG_UNLOCK_KEY) begin
                lock_nxt = pfcg_pkg::PFCG_UNLOCKED; // RULE1
            end else begin
                lock_nxt = pfcg_pkg::PFCG_LOCKED; // RULE2
            end
        end else if (bus.write && bus.addr == `PFCG_OFS_COMMIT) begin
            lock_nxt = pfcg_pkg::PFCG_LOCKED; // RULE2
        end
    end
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (bus.read) begin
            unique case (bus.addr)
                `PFCG_OFS_LOCK: rdata_nxt = (lock_r == pfcg_pkg::PFCG_LOCKED) ?
                    `PFCG_LOCKED_WORD : `PFCG_UNLOCKED_WORD; // RULE3
                `PFCG_OFS_COMMIT: rdata_nxt = {24'h00_0000, commit_bits}; // RULE11
                `PFCG_OFS_AFSEL: rdata_nxt = {24'h00_0000, alt_function_select};
                `PFCG_OFS_ID4: rdata_nxt = {24'h00_0000, IDENT_HI[7:0]}; // RULE12
                `PFCG_OFS_ID5: rdata_nxt = {24'h00_0000, IDENT_HI[15:8]}; // RULE12
                `PFCG_OFS_ID6: rdata_nxt = {24'h00_0000, IDENT_HI[23:16]}; // RULE12
                `PFCG_OFS_ID7: rdata_nxt = {24'h00_0000, IDENT_HI[31:24]}; // RULE12
                `PFCG_OFS_ID0: rdata_nxt = {24'h00_0000, IDENT_LO[7:0]}; // RULE13
                `PFCG_OFS_ID1: rdata_nxt = {24'h00_0000, IDENT_LO[15:8]}; // RULE13
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end
    // Lock resets closed so the debug pins stay protected from power-up.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lock_r <= pfcg_pkg::PFCG_LOCKED;
            rdata_r <= `PFCG_IDLE_WORD;
        end else begin
            lock_r <= lock_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata = rdata_r;
    assign locked = (lock_r == pfcg_pkg::PFCG_LOCKED);

    property p_unlock;
        @(posedge clock) disable iff (reset)
        (write && addr == `PFCG_OFS_LOCK && wdata == `PFCG_UNLOCK_KEY) |=> !locked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("key write did not unlock"); // RULE1
    property p_relock;
        @(posedge clock) disable iff (reset)
        (write && ((addr == `PFCG_OFS_LOCK && wdata != `PFCG_UNLOCK_KEY) || addr == `PFCG_OFS_COMMIT)) |=> locked;
    endproperty
    a_relock: assert property (p_relock) else $error("port did not relock"); // RULE2
    property p_lock_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_LOCK) |=> rdata == {31'h0000_0000, $past(locked)};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock status read wrong"); // RULE3
    property p_discard;
        @(posedge clock) disable iff (reset)
        (write && addr == `PFCG_OFS_AFSEL) |=>
            ((alt_function_select ^ $past(alt_function_select)) & ~$past(commit_bits)) == 8'h00;
    endproperty
    a_discard: assert property (p_discard) else $error("masked select bit changed"); // RULE4
    property p_commit;
        @(posedge clock) disable iff (reset)
        (write && addr == `PFCG_OFS_AFSEL) |=>
            ((alt_function_select ^ $past(wdata[7:0])) & $past(commit_bits)) == 8'h00;
    endproperty
    a_commit: assert property (p_commit) else $error("committed bit not written"); // RULE5
    property p_locked_ignore;
        @(posedge clock) disable iff (reset)
        (write && addr == `PFCG_OFS_COMMIT && locked) |=> $stable(commit_bits);
    endproperty
    a_locked_ignore: assert property (p_locked_ignore) else $error("mask changed while locked"); // RULE6
    property p_hardwired;
        @(posedge clock) disable iff (reset)
        (commit_bits | WRITABLE_MASK) == 8'hFF;
    endproperty
    a_hardwired: assert property (p_hardwired) else $error("ordinary commit bit cleared"); // RULE8
    property p_id_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_ID7) |=> rdata == {24'h00_0000, IDENT_HI[31:24]};
    endproperty
    a_id_read: assert property (p_id_read) else $error("identification byte wrong"); // RULE12

    // These decodes only feed the checks below; the datapath decodes on its own.
    logic id_hit;
    logic addr_mapped;
    assign id_hit = addr >= `PFCG_OFS_ID4 && addr <= `PFCG_OFS_ID1 && addr[1:0] == 2'b00; // RULE13
    assign addr_mapped = id_hit || addr == `PFCG_OFS_LOCK || addr == `PFCG_OFS_COMMIT ||
        addr == `PFCG_OFS_AFSEL;

    sequence s_key_write;
        write && addr == `PFCG_OFS_LOCK && wdata == `PFCG_UNLOCK_KEY;
    endsequence
    sequence s_bad_key_write;
        write && addr == `PFCG_OFS_LOCK && wdata != `PFCG_UNLOCK_KEY;
    endsequence
    sequence s_commit_write;
        write && addr == `PFCG_OFS_COMMIT;
    endsequence
    sequence s_select_write;
        write && addr == `PFCG_OFS_AFSEL;
    endsequence
    sequence s_open_commit;
        !locked ##0 s_commit_write;
    endsequence
    // Unlocking takes one write, so the mask can be stored on the very next access.
    sequence s_store_mask;
        s_key_write ##1 s_commit_write;
    endsequence

    property p_store_mask;
        @(posedge clock) disable iff (reset)
        s_open_commit |=> ((commit_bits ^ $past(wdata[7:0])) & WRITABLE_MASK) == 8'h00;
    endproperty
    a_store_mask: assert property (p_store_mask) else $error("writable commit bit not stored"); // RULE9

    property p_key_opens;
        @(posedge clock) disable iff (reset)
        s_store_mask |=> ((commit_bits ^ $past(wdata[7:0])) & WRITABLE_MASK) == 8'h00;
    endproperty
    a_key_opens: assert property (p_key_opens) else $error("key did not open the mask"); // RULE1

    property p_store_relocks;
        @(posedge clock) disable iff (reset)
        s_store_mask |=> locked;
    endproperty
    a_store_relocks: assert property (p_store_relocks) else $error("mask store left port open"); // RULE2

    property p_bad_key;
        @(posedge clock) disable iff (reset)
        s_bad_key_write |=> locked;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("wrong key left port open"); // RULE2

    property p_commit_relock;
        @(posedge clock) disable iff (reset)
        s_commit_write |=> locked;
    endproperty
    a_commit_relock: assert property (p_commit_relock) else $error("mask write left port open"); // RULE2

    property p_mask_hold;
        @(posedge clock) disable iff (reset)
        !(write && addr == `PFCG_OFS_COMMIT && !locked) |=> $stable(commit_bits);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved without open write"); // RULE6

    property p_lock_hold;
        @(posedge clock) disable iff (reset)
        !(write && (addr == `PFCG_OFS_LOCK || addr == `PFCG_OFS_COMMIT)) |=> $stable(locked);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock moved without a write"); // RULE2

    property p_ordinary_commit;
        @(posedge clock) disable iff (reset)
        s_select_write |=> ((alt_function_select ^ $past(wdata[7:0])) & ~WRITABLE_MASK) == 8'h00;
    endproperty
    a_ordinary_commit: assert property (p_ordinary_commit) else $error("ordinary select bit refused"); // RULE8

    property p_select_hold;
        @(posedge clock) disable iff (reset)
        !(write && addr == `PFCG_OFS_AFSEL) |=> $stable(alt_function_select);
    endproperty
    a_select_hold: assert property (p_select_hold) else $error("select moved without a write"); // RULE4

    property p_select_mask_hold;
        @(posedge clock) disable iff (reset)
        s_select_write |=> $stable(commit_bits);
    endproperty
    a_select_mask_hold: assert property (p_select_mask_hold) else $error("select write moved mask"); // RULE4

    // The mask data sit two cycles back and the select data one cycle back.
    property p_new_mask;
        @(posedge clock) disable iff (reset)
        s_store_mask ##1 s_select_write |=>
            ((alt_function_select ^ $past(wdata[7:0])) & ($past(wdata[7:0], 2) | ~WRITABLE_MASK)) == 8'h00;
    endproperty
    a_new_mask: assert property (p_new_mask) else $error("new mask did not govern select"); // RULE14

    property p_locked_word;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_LOCK && locked) |=> rdata == `PFCG_LOCKED_WORD;
    endproperty
    a_locked_word: assert property (p_locked_word) else $error("locked status word wrong"); // RULE3

    property p_unlocked_word;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_LOCK && !locked) |=> rdata == `PFCG_UNLOCKED_WORD;
    endproperty
    a_unlocked_word: assert property (p_unlocked_word) else $error("unlocked status word wrong"); // RULE3

    property p_key_read;
        @(posedge clock) disable iff (reset)
        s_key_write ##1 (read && addr == `PFCG_OFS_LOCK) |=> rdata == `PFCG_UNLOCKED_WORD;
    endproperty
    a_key_read: assert property (p_key_read) else $error("status after key not open"); // RULE3

    property p_mask_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_COMMIT) |=> rdata == {24'h00_0000, $past(commit_bits)};
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); // RULE7

    property p_select_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_AFSEL) |=> rdata == {24'h00_0000, $past(alt_function_select)};
    endproperty
    a_select_read: assert property (p_select_read) else $error("select read wrong"); // RULE11

    property p_high_zero;
        @(posedge clock) disable iff (reset)
        read |=> rdata[31:8] == 24'h00_0000;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("reserved read bits not zero"); // RULE11

    property p_id4_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_ID4) |=> rdata == {24'h00_0000, IDENT_HI[7:0]};
    endproperty
    a_id4_read: assert property (p_id4_read) else $error("identification byte four wrong"); // RULE12

    property p_id5_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_ID5) |=> rdata == {24'h00_0000, IDENT_HI[15:8]};
    endproperty
    a_id5_read: assert property (p_id5_read) else $error("identification byte five wrong"); // RULE12

    property p_id6_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_ID6) |=> rdata == {24'h00_0000, IDENT_HI[23:16]};
    endproperty
    a_id6_read: assert property (p_id6_read) else $error("identification byte six wrong"); // RULE12

    property p_id0_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_ID0) |=> rdata == {24'h00_0000, IDENT_LO[7:0]};
    endproperty
    a_id0_read: assert property (p_id0_read) else $error("identification byte zero wrong"); // RULE12

    property p_id1_read;
        @(posedge clock) disable iff (reset)
        (read && addr == `PFCG_OFS_ID1) |=> rdata == {24'h00_0000, IDENT_LO[15:8]};
    endproperty
    a_id1_read: assert property (p_id1_read) else $error("identification byte one wrong"); // RULE12

    property p_id_write;
        @(posedge clock) disable iff (reset)
        (write && id_hit) |=> $stable(commit_bits) && $stable(alt_function_select) && $stable(locked);
    endproperty
    a_id_write: assert property (p_id_write) else $error("identification write had an effect"); // RULE13

    property p_unmapped_read;
        @(posedge clock) disable iff (reset)
        (read && !addr_mapped) |=> rdata == `PFCG_IDLE_WORD;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // RULE13

    // Read data are zero outside the answer cycle, so a bus mux may simply OR them.
    property p_idle_rdata;
        @(posedge clock) disable iff (reset)
        !read |=> rdata == `PFCG_IDLE_WORD;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data stood too long"); // RULE3
endmodule : pfcg_commit_guard
`default_nettype wire

// ### verif/test_pin_function_commit_guard.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfcg_defs.svh"
module test_pin_function_commit_guard;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic write = 1'b0;
    logic read = 1'b0;
    logic [31:0] rdata;
    logic [7:0] alt_function_select;
    logic [7:0] commit_bits;
    logic locked;
    logic [7:0] select_c;
    logic [7:0] commit_c;
    logic [7:0] select_a;
    logic [7:0] commit_a;
    int mismatches = 0;
    int total_checks = 0;
    // Identifier values are arbitrary; distinct bytes expose a swapped lane.
    pfcg_commit_guard #(.PORT_ID(`PFCG_PORT_B), .IDENT_LO(32'h8877_6655), .IDENT_HI(32'h4433_2211)) dut (
        .clock(clock),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .write(write),
        .read(read),
        .rdata(rdata),
        .alt_function_select(alt_function_select),
        .commit_bits(commit_bits),
        .locked(locked)
    );
    // The other two ports share the bus, so they see every access port B sees.
    pfcg_commit_guard #(.PORT_ID(`PFCG_PORT_C)) dut_c (
        .clock(clock),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .write(write),
        .read(read),
        .rdata(),
        .alt_function_select(select_c),
        .commit_bits(commit_c),
        .locked()
    );
    pfcg_commit_guard #(.PORT_ID(`PFCG_PORT_A)) dut_a (
        .clock(clock),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .write(write),
        .read(read),
        .rdata(),
        .alt_function_select(select_a),
        .commit_bits(commit_a),
        .locked()
    );
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clock);
        write <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        read <= 1'b1;
        @(posedge clock);
        read <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd
    task automatic t_reset();
        chk({24'h00_0000, commit_bits}, 32'h0000_007F);
        chk({31'h0000_0000, locked}, 32'h0000_0001);
        chk({24'h00_0000, alt_function_select}, 32'h0000_0080);
        chk({24'h00_0000, commit_c}, 32'h0000_00F0);
        chk({24'h00_0000, select_c}, 32'h0000_000F);
        chk({24'h00_0000, commit_a}, 32'h0000_00FF);
        chk({24'h00_0000, select_a}, 32'h0000_0000);
        rd(`PFCG_OFS_COMMIT, 32'h0000_007F);
        rd(`PFCG_OFS_LOCK, `PFCG_LOCKED_WORD);
        @(posedge clock);
        #1;
        chk(rdata, `PFCG_IDLE_WORD);
    endtask : t_reset
    task automatic t_locked();
        wr(`PFCG_OFS_COMMIT, 32'h0000_0080);
        rd(`PFCG_OFS_COMMIT, 32'h0000_007F);
    endtask : t_locked
    task automatic t_select();
        wr(`PFCG_OFS_AFSEL, 32'h0000_0000);
        chk({24'h00_0000, alt_function_select}, 32'h0000_0080);
        chk({24'h00_0000, select_c}, 32'h0000_000F);
        chk({24'h00_0000, select_a}, 32'h0000_0000);
        wr(`PFCG_OFS_AFSEL, 32'h0000_007F);
        chk({24'h00_0000, alt_function_select}, 32'h0000_00FF);
        chk({24'h00_0000, select_c}, 32'h0000_007F);
        chk({24'h00_0000, select_a}, 32'h0000_007F);
    endtask : t_select
    task automatic t_unlock();
        wr(`PFCG_OFS_LOCK, `PFCG_UNLOCK_KEY);
        rd(`PFCG_OFS_LOCK, `PFCG_UNLOCKED_WORD);
        wr(`PFCG_OFS_LOCK, 32'h1ACC_E550);
        rd(`PFCG_OFS_LOCK, `PFCG_LOCKED_WORD);
        wr(`PFCG_OFS_LOCK, `PFCG_UNLOCK_KEY);
        wr(`PFCG_OFS_COMMIT, 32'hFFFF_FF80);
        wr(`PFCG_OFS_AFSEL, 32'h0000_0000);
        chk({24'h00_0000, alt_function_select}, 32'h0000_0000);
        chk({24'h00_0000, commit_c}, 32'h0000_00F0);
        chk({24'h00_0000, select_c}, 32'h0000_000F);
        rd(`PFCG_OFS_COMMIT, 32'h0000_00FF);
        rd(`PFCG_OFS_LOCK, `PFCG_LOCKED_WORD);
        wr(`PFCG_OFS_LOCK, `PFCG_UNLOCK_KEY);
        wr(`PFCG_OFS_COMMIT, 32'h0000_0000);
        rd(`PFCG_OFS_COMMIT, 32'h0000_007F);
        // Pin 7 is uncommitted again, so only the ordinary pins take the ones.
        wr(`PFCG_OFS_AFSEL, 32'h0000_00FF);
        chk({24'h00_0000, alt_function_select}, 32'h0000_007F);
        wr(`PFCG_OFS_LOCK, `PFCG_UNLOCK_KEY);
        wr(`PFCG_OFS_COMMIT, 32'h0000_000F);
        chk({24'h00_0000, commit_c}, 32'h0000_00FF);
        chk({24'h00_0000, commit_bits}, 32'h0000_007F);
        wr(`PFCG_OFS_AFSEL, 32'h0000_0000);
        chk({24'h00_0000, select_c}, 32'h0000_0000);
    endtask : t_unlock
    task automatic t_ident();
        logic [11:0] ofs [6] = '{12'hFD0, 12'hFD4, 12'hFD8, 12'hFDC, 12'hFE0, 12'hFE4};
        logic [31:0] exp [6] = '{32'h0000_0011, 32'h0000_0022, 32'h0000_0033,
            32'h0000_0044, 32'h0000_0055, 32'h0000_0066};
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], 32'hFFFF_FFFF);
            rd(ofs[i], exp[i]);
        end
        rd(12'h100, 32'h0000_0000);
    endtask : t_ident
    task automatic end_sim();
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        #1;
        t_reset();
        t_locked();
        t_select();
        t_unlock();
        t_ident();
        end_sim();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
endmodule : test_pin_function_commit_guard
`default_nettype wire
